// *** cmsw_cfg.svh ***
// Constants of the conversion mode command decoder.
// Assumes inclusion by bare name from the decoder and the test bench.
`ifndef CMSW_CFG_SVH
`define CMSW_CFG_SVH
`define CMSW_DEV_ADDR_HI   4'h9
`define CMSW_LOC_CFG_MSB   8'hAC
`define CMSW_CMD_START     8'h51
`define CMSW_CMD_COPY      8'h48
`define CMSW_CMD_STOP      8'h22
`define CMSW_CFG_RESET     8'h01
`define CMSW_SCS_BIT       0
`define CMSW_COPY_TIME_MS  10
`define CMSW_CLK_KHZ       40000
`define CMSW_COPY_CYCLES   (`CMSW_COPY_TIME_MS * `CMSW_CLK_KHZ)
`endif

// *** cmsw_decoder.sv ***
// Serial command decoder of the sensor: address, location, data, commands.
// Behaviour
// [R01] Master opens with START, address, write bit.
// [R02] Sensor acknowledges address, command and data bytes.
// [R03] Location ACh selects configuration register MSB.
// [R04] Configuration write updates only the SRAM shadow.
// [R05] Data bit 0 clear selects continuous conversion.
// [R06] Command 51h is acknowledged and starts conversions.
// [R07] Command 48h is acknowledged and copies SRAM.
// [R08] Repeated START and address between commands.
// [R09] Order: configuration write, start, then copy.
// [R10] Master ends with STOP or repeated START.
// [R11] Master waits 10 ms or polls busy.
// Assumes pins sampled through cmsw_sync; open-drain sda by enable.
`timescale 1ns/10ps
`default_nettype none
`include "cmsw_cfg.svh"
module cmsw_decoder
    import cmsw_pkg::*;
#(
    parameter int COPY_CYCLES = `CMSW_COPY_CYCLES
)
(
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Serial pins.
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    // Bus address straps.
    input  wire logic [2:0] addr_pins,
    // Device state.
    output logic [7:0]      cfg_sram,
    output logic [7:0]      cfg_eeprom,
    output logic            single_conversion_select,
    output logic            converting,
    output logic            nonvolatile_write_busy_flag
);
    // ==========================================
    // Pin sampling.
    cmsw_pins_t pins_s;
    cmsw_ev_t   ev;
    cmsw_sync u_sync (
        .clk     (clk),
        .rst_n   (rst_n),
        .pins_in ({scl_i, sda_i}),
        .pins_s  (pins_s),
        .ev      (ev)
    );

    // ==========================================
    // Byte framing state machine.
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_BITS = 5'h02,
        ST_ACK  = 5'h04,
        ST_ACKH = 5'h08,
        ST_SKIP = 5'h10
    } cmsw_st_t;
    typedef enum logic [2:0] {PH_ADDR = 3'h1, PH_CMD = 3'h2, PH_DATA = 3'h4} cmsw_ph_t;

    cmsw_st_t    st_r;
    cmsw_ph_t    ph_r;
    logic [7:0]  sh_r;
    logic [2:0]  cnt_r;
    logic [7:0]  byte_w;
    logic        addr_hit;
    logic [2:0]  addr_pins_s1_r;
    logic [2:0]  addr_r;
    logic        is_byte_end;
    logic        copy_go;
    logic [31:0] busy_cnt_r;

    assign byte_w      = {sh_r[6:0], pins_s.sda};
    assign addr_hit    = (byte_w[7:1] == {`CMSW_DEV_ADDR_HI, addr_r}) && !byte_w[0]; // R01
    assign is_byte_end = (st_r == ST_BITS) && ev.rise && (cnt_r == 3'h7);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            addr_pins_s1_r <= 3'h0;
            addr_r         <= 3'h0;
        end else begin
            addr_pins_s1_r <= addr_pins;
            addr_r         <= addr_pins_s1_r;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r  <= ST_IDLE;
            ph_r  <= PH_ADDR;
            sh_r  <= 8'h00;
            cnt_r <= 3'h0;
        end else if (ev.start) begin // R08
            st_r  <= ST_BITS;
            ph_r  <= PH_ADDR;
            cnt_r <= 3'h0;
        end else if (ev.stop) begin // R10
            st_r <= ST_IDLE;
        end else begin
            case (st_r)
                ST_IDLE: st_r <= ST_IDLE;
                ST_BITS: begin
                    if (ev.rise) begin
                        sh_r  <= byte_w;
                        cnt_r <= cnt_r + 3'h1;
                        if (cnt_r == 3'h7) begin
                            if (ph_r != PH_ADDR || addr_hit) begin
                                st_r <= ST_ACK;
                            end else begin
                                st_r <= ST_SKIP;
                            end
                        end
                    end
                end
                ST_ACK: if (ev.fall) st_r <= ST_ACKH;
                ST_ACKH: begin
                    if (ev.fall) begin
                        st_r <= ST_BITS;
                        if (ph_r == PH_ADDR) begin
                            ph_r <= PH_CMD;
                        end else if (ph_r == PH_CMD && sh_r == `CMSW_LOC_CFG_MSB) begin
                            ph_r <= PH_DATA; // R03
                        end else begin
                            ph_r <= PH_CMD;
                        end
                    end
                end
                ST_SKIP: st_r <= ST_SKIP;
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    // ==========================================
    // Acknowledge drive, low through the ninth clock.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sda_oe <= 1'b0;
        end else begin
            // Drive only after the eighth clock has fallen, so a long high phase never sees a false START.
            sda_oe <= (st_r == ST_ACKH) && !ev.start && !ev.stop; // R02
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sda_o <= 1'b0;
        end else begin
            sda_o <= 1'b0;
        end
    end

    // ==========================================
    // Configuration shadow and commands.
    assign copy_go = is_byte_end && ph_r == PH_CMD && byte_w == `CMSW_CMD_COPY;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_sram <= `CMSW_CFG_RESET;
        end else if (is_byte_end && ph_r == PH_DATA) begin
            cfg_sram <= byte_w; // R04 R05
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            single_conversion_select <= 1'b1;
        end else begin
            single_conversion_select <= cfg_sram[`CMSW_SCS_BIT]; // R05
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            converting <= 1'b0;
        end else if (is_byte_end && ph_r == PH_CMD && byte_w == `CMSW_CMD_START) begin
            converting <= 1'b1; // R06
        end else if (is_byte_end && ph_r == PH_CMD && byte_w == `CMSW_CMD_STOP) begin
            converting <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_eeprom                  <= `CMSW_CFG_RESET;
            nonvolatile_write_busy_flag <= 1'b0;
            busy_cnt_r                  <= 32'h0;
        end else if (copy_go && !nonvolatile_write_busy_flag) begin
            cfg_eeprom                  <= cfg_sram; // R07
            nonvolatile_write_busy_flag <= 1'b1; // R11
            busy_cnt_r                  <= 32'(COPY_CYCLES - 1);
        end else if (nonvolatile_write_busy_flag) begin
            if (busy_cnt_r == 32'h0) begin
                nonvolatile_write_busy_flag <= 1'b0;
            end else begin
                busy_cnt_r <= busy_cnt_r - 32'h1;
            end
        end
    end

    // ==========================================
    // Checks.
    sequence s_cmd_end(logic [7:0] c);
        is_byte_end && ph_r == PH_CMD && byte_w == c;
    endsequence

    AST_ACK_ADDR: assert property (@(posedge clk) disable iff (!rst_n) // R02
        (is_byte_end && ph_r == PH_ADDR && addr_hit) |-> ##1 st_r == ST_ACK)
        else $error("address not acknowledged");
    AST_NO_ACK_MISS: assert property (@(posedge clk) disable iff (!rst_n) // R01
        (is_byte_end && ph_r == PH_ADDR && !addr_hit && !ev.start && !ev.stop) |-> ##1 st_r == ST_SKIP)
        else $error("foreign address acknowledged");
    AST_ACK_DRIVE: assert property (@(posedge clk) disable iff (!rst_n) // R02
        (st_r == ST_ACKH && !ev.start && !ev.stop) |-> ##1 sda_oe)
        else $error("ack not driven");
    AST_LOC_DATA: assert property (@(posedge clk) disable iff (!rst_n) // R03
        (st_r == ST_ACKH && ev.fall && ph_r == PH_CMD && sh_r == `CMSW_LOC_CFG_MSB && !ev.start && !ev.stop)
        |-> ##1 ph_r == PH_DATA)
        else $error("location did not select data phase");
    AST_SRAM_ONLY: assert property (@(posedge clk) disable iff (!rst_n) // R04
        (is_byte_end && ph_r == PH_DATA && !copy_go) |-> ##1 $stable(cfg_eeprom))
        else $error("eeprom changed by data write");
    AST_CONT_MODE: assert property (@(posedge clk) disable iff (!rst_n) // R05
        (is_byte_end && ph_r == PH_DATA && !byte_w[0] && !ev.start && !ev.stop) |-> ##2 !single_conversion_select)
        else $error("continuous mode not entered");
    AST_START_CONV: assert property (@(posedge clk) disable iff (!rst_n) // R06
        s_cmd_end(`CMSW_CMD_START) |-> ##1 converting ##0 st_r == ST_ACK)
        else $error("start command not honoured");
    AST_COPY: assert property (@(posedge clk) disable iff (!rst_n) // R07
        (s_cmd_end(`CMSW_CMD_COPY) ##0 !nonvolatile_write_busy_flag)
        |-> ##1 (cfg_eeprom == $past(cfg_sram) && nonvolatile_write_busy_flag))
        else $error("copy not performed");
    AST_RESTART: assert property (@(posedge clk) disable iff (!rst_n) // R08
        ev.start |-> ##1 (st_r == ST_BITS && ph_r == PH_ADDR && cnt_r == 3'h0))
        else $error("repeated start not handled");
    AST_STOP: assert property (@(posedge clk) disable iff (!rst_n) // R10
        (ev.stop && !ev.start) |-> ##1 st_r == ST_IDLE ##1 !sda_oe)
        else $error("stop did not release bus");
endmodule : cmsw_decoder
`default_nettype wire

// *** cmsw_master.sv ***
// Behavioural 2-wire bus master that drives the decoder's serial pins.
// Assumes the bench resolves sda with a pull-up from all open-drain drivers.
`timescale 1ns/10ps
`default_nettype none
module cmsw_master (
    // Clock.
    input  wire logic clk,
    // Serial pins.
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    // ====================================
    // Bus phases
    initial begin
        scl     = 1'h1;
        sda_low = 1'h0;
    end
    task automatic gap(input int n);
        repeat (n) @(posedge clk);
    endtask : gap
    // A start and a repeated start both pull sda low while scl is high.
    task automatic start;
        sda_low <= 1'h0;
        gap(3);
        scl <= 1'h1;
        gap(4);
        sda_low <= 1'h1;
        gap(4);
        scl <= 1'h0;
        gap(3);
    endtask : start
    task automatic stop;
        sda_low <= 1'h1;
        gap(3);
        scl <= 1'h1;
        gap(4);
        sda_low <= 1'h0;
        gap(4);
    endtask : stop
    // Sends one byte MSB first with 6 clocks low and 2 high, then samples the acknowledge.
    task automatic wr(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_low <= ~b[i];
            gap(3);
            scl <= 1'h1;
            gap(2);
            scl <= 1'h0;
            gap(3);
        end
        sda_low <= 1'h0;
        gap(3);
        scl <= 1'h1;
        gap(2);
        ack = (sda === 1'h0);
        scl <= 1'h0;
        gap(3);
    endtask : wr
endmodule : cmsw_master
`default_nettype wire

// *** cmsw_pkg.sv ***
// Types of the conversion mode command decoder.
// Assumes cmsw_cfg.svh is on the include path.
`default_nettype none
package cmsw_pkg;
    typedef struct packed {
        logic scl;
        logic sda;
    } cmsw_pins_t;
    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
    } cmsw_ev_t;
endpackage : cmsw_pkg
`default_nettype wire

// *** cmsw_sync.sv ***
// Two-flop synchronisers and edge/condition detection of the serial pins.
// Assumes pins are asynchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module cmsw_sync
    import cmsw_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Raw pins in, events and levels out.
    input  var  cmsw_pins_t pins_in,
    output var  cmsw_pins_t pins_s,
    output var  cmsw_ev_t   ev
);
    cmsw_pins_t meta_r;
    cmsw_pins_t sync_r;
    cmsw_pins_t last_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_r <= 2'h3;
            sync_r <= 2'h3;
            last_r <= 2'h3;
        end else begin
            meta_r <= pins_in;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign pins_s   = sync_r;
    assign ev.rise  = sync_r.scl & ~last_r.scl;
    assign ev.fall  = ~sync_r.scl & last_r.scl;
    assign ev.start = sync_r.scl & last_r.scl & last_r.sda & ~sync_r.sda;
    assign ev.stop  = sync_r.scl & last_r.scl & ~last_r.sda & sync_r.sda;
endmodule : cmsw_sync
`default_nettype wire

// *** conversion_mode_switch_sequence_test.sv ***
// Self-checking bench of the decoder driven by the behavioural bus master.
// Assumes cmsw_cfg.svh on the include path; copy time shortened to 50 clocks.
`timescale 1ns/10ps
`default_nettype none
`include "cmsw_cfg.svh"
module conversion_mode_switch_sequence_test;
    logic       clk;
    logic       rst_n;
    logic [2:0] addr_pins;
    wire        scl;
    wire        sda_low;
    wire        sda_o;
    wire        sda_oe;
    wire        sda;
    wire        sel;
    wire        conv;
    wire        busy;
    wire  [7:0] cfg_sram;
    wire  [7:0] cfg_eeprom;
    wire  [7:0] dev_w;
    int         fails;
    int         checked;
    assign sda   = ~(sda_low | (sda_oe & ~sda_o));
    assign dev_w = {`CMSW_DEV_ADDR_HI, addr_pins, 1'h0};
    cmsw_decoder #(.COPY_CYCLES(50)) u_cmsw_decoder (.clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .addr_pins(addr_pins), .cfg_sram(cfg_sram), .cfg_eeprom(cfg_eeprom),
        .single_conversion_select(sel), .converting(conv), .nonvolatile_write_busy_flag(busy));
    cmsw_master u_cmsw_master (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    // ====================================
    // Shared tasks
    task automatic compare(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : compare
    task automatic conclude;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude
    task automatic send(input logic [7:0] b, input logic ack_exp);
        logic a;
        u_cmsw_master.wr(b, a);
        compare("acknowledge", {7'h00, ack_exp}, {7'h00, a});
    endtask : send
    task automatic open_write;
        u_cmsw_master.start();
        send(dev_w, 1'h1);
    endtask : open_write
    // ====================================
    // Scenarios
    task automatic check_reset;
        compare("cfg_sram", 8'h01, cfg_sram);
        compare("cfg_eeprom", 8'h01, cfg_eeprom);
        compare("select", 8'h01, {7'h00, sel});
        compare("converting", 8'h00, {7'h00, conv});
        compare("busy", 8'h00, {7'h00, busy});
        compare("sda_oe", 8'h00, {7'h00, sda_oe});
    endtask : check_reset
    task automatic to_continuous;
        int n;
        open_write();
        send(8'hAC, 1'h1);
        send(8'hFE, 1'h1);
        compare("cfg_sram", 8'hFE, cfg_sram);
        compare("cfg_eeprom", 8'h01, cfg_eeprom);
        compare("select", 8'h00, {7'h00, sel});
        open_write();
        send(8'h51, 1'h1);
        compare("converting", 8'h01, {7'h00, conv});
        open_write();
        send(8'h48, 1'h1);
        compare("busy", 8'h01, {7'h00, busy});
        compare("cfg_eeprom", 8'hFE, cfg_eeprom);
        u_cmsw_master.stop();
        n = 0;
        while (busy !== 1'h0 && n < 200) begin
            @(posedge clk);
            n++;
        end
        if (n >= 200) begin
            fails++;
            conclude();
        end
        compare("busy after copy", 8'h00, {7'h00, busy});
        compare("select after copy", 8'h00, {7'h00, sel});
    endtask : to_continuous
    task automatic refused;
        u_cmsw_master.start();
        send({`CMSW_DEV_ADDR_HI, addr_pins ^ 3'h1, 1'h0}, 1'h0);
        send(8'hAC, 1'h0);
        send(8'h01, 1'h0);
        u_cmsw_master.start();
        send(dev_w | 8'h01, 1'h0);
        u_cmsw_master.stop();
        compare("cfg_sram", 8'hFE, cfg_sram);
    endtask : refused
    task automatic back_to_single;
        open_write();
        send(8'hAC, 1'h1);
        send(8'h01, 1'h1);
        compare("select", 8'h01, {7'h00, sel});
        compare("cfg_eeprom", 8'hFE, cfg_eeprom);
        open_write();
        send(8'h22, 1'h1);
        compare("converting", 8'h00, {7'h00, conv});
        u_cmsw_master.stop();
    endtask : back_to_single
    initial begin
        fails     = 0;
        checked   = 0;
        rst_n     = 1'h0;
        addr_pins = 3'h5;
        repeat (6) @(posedge clk);
        check_reset();
        rst_n <= 1'h1;
        repeat (4) @(posedge clk);
        to_continuous();
        refused();
        back_to_single();
        conclude();
    end
endmodule : conversion_mode_switch_sequence_test
`default_nettype wire
